//--- design/sbcu_top.sv
// Sixteen bit counter unit with its byte wide CPU port.
module sbcu_top
    import sbcu_pkg::*;
(
    input  wire logic              sys_clk,             // System clock.
    input  wire logic              rst,                 // Synchronous reset, active high.
    input  wire logic [ADDR_W-1:0] cpu_addr,            // Byte location address.
    input  wire logic              cpu_wr,              // Write strobe.
    input  wire logic              cpu_rd,              // Read strobe.
    input  wire logic [7:0]        cpu_wdata,           // Write data.
    output logic      [7:0]        cpu_rdata,           // Read data, next cycle.
    input  wire logic              ext_tick_pin,        // External tick pin.
    output logic                   count_overflow_flag, // Sticky overflow flag.
    output logic                   cnt_at_top,          // Count equals top.
    output logic                   cnt_at_bottom        // Count equals zero.
);
    sbcu_ctl_if ctl ();

    logic [2:0]  tick_source_select_reg;
    logic [3:0]  waveform_mode_select_reg;
    logic [7:0]  temp_reg;
    logic [15:0] timer_count_value_reg;
    logic [15:0] timer_count_value_next;
    sbcu_dir_t   dir_reg;
    sbcu_dir_t   dir_next;
    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_b_reg;
    logic [15:0] capture_value_reg;
    logic        ovf_reg;
    logic        ovf_set;
    logic [7:0]  rdata_reg;
    logic        at_top_reg;
    logic        at_bot_reg;

    logic wr_ctl_a;
    logic wr_ctl_b;
    logic wr_cnt_lo;
    logic wr_cmpa_lo;
    logic wr_cmpb_lo;
    logic wr_cap_lo;
    logic wr_any_hi;
    logic wr_flag;
    logic rd_cnt_lo;
    logic rd_cap_lo;

    sbcu_tick_gen u_tick (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .ext_tick_pin (ext_tick_pin),
        .ctl          (ctl.tick_mp)
    );

    sbcu_mode_dec u_mode (
        .ctl (ctl.mode_mp)
    );

    // Settings and limit values handed to the helpers.
    assign ctl.cs    = tick_source_select_reg;
    assign ctl.wgm   = waveform_mode_select_reg;
    assign ctl.cmp_a = cmp_a_reg;
    assign ctl.cap   = capture_value_reg;

    // Address decode of the byte locations.
    assign wr_ctl_a   = cpu_wr && (cpu_addr == CTRL_A_OFS);
    assign wr_ctl_b   = cpu_wr && (cpu_addr == CTRL_B_OFS);
    assign wr_cnt_lo  = cpu_wr && (cpu_addr == CNT_LO_OFS);
    assign wr_cmpa_lo = cpu_wr && (cpu_addr == CMPA_LO_OFS);
    assign wr_cmpb_lo = cpu_wr && (cpu_addr == CMPB_LO_OFS);
    assign wr_cap_lo  = cpu_wr && (cpu_addr == CAP_LO_OFS);
    assign wr_flag    = cpu_wr && (cpu_addr == FLAG_OFS);
    assign wr_any_hi  = cpu_wr && ((cpu_addr == CNT_HI_OFS) || (cpu_addr == CMPA_HI_OFS)
                        || (cpu_addr == CMPB_HI_OFS) || (cpu_addr == CAP_HI_OFS));
    assign rd_cnt_lo  = cpu_rd && (cpu_addr == CNT_LO_OFS);
    assign rd_cap_lo  = cpu_rd && (cpu_addr == CAP_LO_OFS);

    // Tick source and waveform mode fields, both zero after reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_source_select_reg   <= CS_RST;
            waveform_mode_select_reg <= WGM_RST;
        end else begin
            if (wr_ctl_a) begin
                waveform_mode_select_reg[1:0] <= cpu_wdata[CTLA_WGM_LSB +: 2];
            end
            if (wr_ctl_b) begin
                waveform_mode_select_reg[3:2] <= cpu_wdata[CTLB_WGM_LSB +: 2];
                tick_source_select_reg        <= cpu_wdata[CTLB_CS_LSB +: 3];
            end
        end
    end

    // One holding latch for all wide registers; a low write leaves it alone.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            temp_reg <= TEMP_RST;
        end else if (wr_any_hi) begin
            temp_reg <= cpu_wdata;
        end else if (rd_cnt_lo) begin
            temp_reg <= timer_count_value_reg[15:8];
        end else if (rd_cap_lo) begin
            temp_reg <= capture_value_reg[15:8];
        end
    end

    // Next count: a CPU write wins, otherwise a tick steps per sequence.
    always_comb begin
        timer_count_value_next = timer_count_value_reg;
        dir_next               = dir_reg;
        ovf_set                = 1'b0;
        if (wr_cnt_lo) begin
            timer_count_value_next = {temp_reg, cpu_wdata};
        end else if (ctl.tick) begin
            if (ctl.dual_slope) begin
                case (dir_reg)
                    DIR_UP: begin
                        if (timer_count_value_reg >= ctl.top_val) begin
                            timer_count_value_next = timer_count_value_reg - 16'h0001;
                            dir_next               = DIR_DOWN;
                        end else begin
                            timer_count_value_next = timer_count_value_reg + 16'h0001;
                        end
                    end
                    DIR_DOWN: begin
                        if (timer_count_value_reg == CNT_RST) begin
                            timer_count_value_next = timer_count_value_reg + 16'h0001;
                            dir_next               = DIR_UP;
                        end else begin
                            timer_count_value_next = timer_count_value_reg - 16'h0001;
                        end
                    end
                    default: dir_next = DIR_UP;
                endcase
            end else if (ctl.wrap_top && (timer_count_value_reg == ctl.top_val)) begin
                timer_count_value_next = CNT_RST;
            end else begin
                timer_count_value_next = timer_count_value_reg + 16'h0001;
            end
            case (ctl.ovf_sel)
                OVF_AT_MAX:    ovf_set = timer_count_value_reg == CNT_MAX;
                OVF_AT_TOP:    ovf_set = timer_count_value_reg == ctl.top_val;
                OVF_AT_BOTTOM: ovf_set = (dir_reg == DIR_DOWN)
                                         && (timer_count_value_next == CNT_RST);
                default:       ovf_set = 1'b0;
            endcase
        end
    end

    // Counter and slope direction.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_count_value_reg <= CNT_RST;
            dir_reg               <= DIR_UP;
        end else begin
            timer_count_value_reg <= timer_count_value_next;
            dir_reg               <= dir_next;
        end
    end

    // Compare and capture registers load as a whole on the low byte write.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp_a_reg         <= REG_RST;
            cmp_b_reg         <= REG_RST;
            capture_value_reg <= REG_RST;
        end else begin
            if (wr_cmpa_lo) cmp_a_reg <= {temp_reg, cpu_wdata};
            if (wr_cmpb_lo) cmp_b_reg <= {temp_reg, cpu_wdata};
            if (wr_cap_lo) capture_value_reg <= {temp_reg, cpu_wdata};
        end
    end

    // Overflow flag; a set in the clearing cycle wins.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovf_reg <= 1'b0;
        end else if (ovf_set) begin
            ovf_reg <= 1'b1;
        end else if (wr_flag && cpu_wdata[FLAG_OVF_BIT]) begin
            ovf_reg <= 1'b0;
        end
    end

    // Top and bottom indications follow the count register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            at_top_reg <= 1'b0;
            at_bot_reg <= 1'b1;
        end else begin
            at_top_reg <= timer_count_value_next == ctl.top_val;
            at_bot_reg <= timer_count_value_next == CNT_RST;
        end
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (cpu_rd) begin
            case (cpu_addr)
                CTRL_A_OFS:  rdata_reg <= {6'h00, waveform_mode_select_reg[1:0]};
                CTRL_B_OFS:  rdata_reg <= {3'h0, waveform_mode_select_reg[3:2],
                                           tick_source_select_reg};
                CNT_LO_OFS:  rdata_reg <= timer_count_value_reg[7:0];
                CNT_HI_OFS:  rdata_reg <= temp_reg;
                CMPA_LO_OFS: rdata_reg <= cmp_a_reg[7:0];
                CMPA_HI_OFS: rdata_reg <= cmp_a_reg[15:8];
                CMPB_LO_OFS: rdata_reg <= cmp_b_reg[7:0];
                CMPB_HI_OFS: rdata_reg <= cmp_b_reg[15:8];
                CAP_LO_OFS:  rdata_reg <= capture_value_reg[7:0];
                CAP_HI_OFS:  rdata_reg <= temp_reg;
                FLAG_OFS:    rdata_reg <= {7'h00, ovf_reg};
                default:     rdata_reg <= 8'h00;
            endcase
        end
    end

    assign cpu_rdata           = rdata_reg;
    assign count_overflow_flag = ovf_reg;
    assign cnt_at_top          = at_top_reg;
    assign cnt_at_bottom       = at_bot_reg;

    // Checks on the counter and the holding latch.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    stop_hold_a: assert property (
        (tick_source_select_reg == CS_RST) && !wr_cnt_lo
        |=> timer_count_value_reg == $past(timer_count_value_reg))
        else $error("Counter moved with no tick source.");

    lo_read_latch_a: assert property (
        rd_cnt_lo && !wr_any_hi |=> temp_reg == $past(timer_count_value_reg[15:8]))
        else $error("Low byte read did not latch the high byte.");

    lo_write_load_a: assert property (
        wr_cnt_lo |=> timer_count_value_reg == {$past(temp_reg), $past(cpu_wdata)})
        else $error("Low byte write did not load the counter.");

    hi_write_temp_a: assert property (
        wr_any_hi && !ctl.tick
        |=> timer_count_value_reg == $past(timer_count_value_reg)
            && temp_reg == $past(cpu_wdata))
        else $error("High byte write reached the counter.");

    step_by_one_a: assert property (
        ctl.tick && !wr_cnt_lo && !ctl.dual_slope && !ctl.wrap_top
        |=> timer_count_value_reg == $past(timer_count_value_reg) + 16'h0001)
        else $error("Counter did not step by one.");

    top_clear_a: assert property (
        ctl.tick && !wr_cnt_lo && ctl.wrap_top && timer_count_value_reg == ctl.top_val
        |=> timer_count_value_reg == CNT_RST)
        else $error("Counter did not clear at top.");

    max_ovf_a: assert property (
        ctl.tick && !wr_cnt_lo && ctl.ovf_sel == OVF_AT_MAX
        && timer_count_value_reg == CNT_MAX |=> ovf_reg ##1 ovf_reg || $past(wr_flag))
        else $error("Overflow flag not set at maximum.");

    cmp_hi_direct_a: assert property (
        cpu_rd && cpu_addr == CMPA_HI_OFS |=> cpu_rdata == $past(cmp_a_reg[15:8]))
        else $error("Compare high byte went through the latch.");

    bottom_flag_a: assert property (
        cnt_at_bottom == (timer_count_value_reg == CNT_RST))
        else $error("Bottom indication disagrees with the count.");

    reset_clear_a: assert property (
        $fell(rst) |-> timer_count_value_reg == CNT_RST && temp_reg == TEMP_RST
                       && tick_source_select_reg == CS_RST)
        else $error("State not cleared by reset.");

    // Further checks on counting, latch, flag and the decoded top.
    latch_keep_a: assert property (
        wr_cnt_lo |=> temp_reg == $past(temp_reg))
        else $error("Low byte write disturbed the holding latch.");

    no_tick_a: assert property (
        tick_source_select_reg == CS_RST |-> !ctl.tick)
        else $error("Tick produced with no tick source.");

    down_step_a: assert property (
        ctl.tick && !wr_cnt_lo && ctl.dual_slope && dir_reg == DIR_DOWN
        && timer_count_value_reg != CNT_RST
        |=> timer_count_value_reg == $past(timer_count_value_reg) - 16'h0001)
        else $error("Counter did not step down by one.");

    bottom_ovf_a: assert property (
        ctl.tick && !wr_cnt_lo && ctl.ovf_sel == OVF_AT_BOTTOM && dir_reg == DIR_DOWN
        && timer_count_value_reg == 16'h0001
        |=> ovf_reg)
        else $error("Overflow flag not set at bottom.");

    write_wins_a: assert property (
        wr_cnt_lo && ctl.tick
        |=> timer_count_value_reg == {$past(temp_reg), $past(cpu_wdata)})
        else $error("Counter write lost to a tick.");

    top_max_a: assert property (
        !ctl.dual_slope && !ctl.wrap_top |-> ctl.top_val == CNT_MAX)
        else $error("Free running sequence top is not the maximum.");

    cmpb_hi_direct_a: assert property (
        cpu_rd && cpu_addr == CMPB_HI_OFS |=> cpu_rdata == $past(cmp_b_reg[15:8]))
        else $error("Compare B high byte went through the latch.");
endmodule // sbcu_top

//--- design/sbcu_pkg.sv
// Constants, types and register map of the sixteen bit counter unit.
package sbcu_pkg;
    localparam int         ADDR_W = 4;
    // Byte locations on the CPU port.
    localparam logic [3:0] CTRL_A_OFS  = 4'h0;
    localparam logic [3:0] CTRL_B_OFS  = 4'h1;
    localparam logic [3:0] CNT_LO_OFS  = 4'h2;
    localparam logic [3:0] CNT_HI_OFS  = 4'h3;
    localparam logic [3:0] CMPA_LO_OFS = 4'h4;
    localparam logic [3:0] CMPA_HI_OFS = 4'h5;
    localparam logic [3:0] CMPB_LO_OFS = 4'h6;
    localparam logic [3:0] CMPB_HI_OFS = 4'h7;
    localparam logic [3:0] CAP_LO_OFS  = 4'h8;
    localparam logic [3:0] CAP_HI_OFS  = 4'h9;
    localparam logic [3:0] FLAG_OFS    = 4'hA;
    // Field positions.
    localparam int CTLA_WGM_LSB = 0;
    localparam int CTLB_CS_LSB  = 0;
    localparam int CTLB_WGM_LSB = 3;
    localparam int FLAG_OVF_BIT = 0;
    // Reset values.
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [7:0]  TEMP_RST = 8'h00;
    localparam logic [2:0]  CS_RST   = 3'h0;
    localparam logic [3:0]  WGM_RST  = 4'h0;
    localparam logic [15:0] REG_RST  = 16'h0000;
    // Count limits.
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] TOP_8B   = 16'h00FF;
    localparam logic [15:0] TOP_9B   = 16'h01FF;
    localparam logic [15:0] TOP_10B  = 16'h03FF;
    // Prescaler tap masks for divide by 8, 64, 256 and 1024.
    localparam logic [9:0]  PRE_D8    = 10'h007;
    localparam logic [9:0]  PRE_D64   = 10'h03F;
    localparam logic [9:0]  PRE_D256  = 10'h0FF;
    localparam logic [9:0]  PRE_D1024 = 10'h3FF;
    typedef enum logic [1:0] {OVF_AT_MAX, OVF_AT_TOP, OVF_AT_BOTTOM} sbcu_ovf_t;
    typedef enum logic {DIR_UP, DIR_DOWN} sbcu_dir_t;
endpackage

//--- design/sbcu_ctl_if.sv
// Control and tick signals shared by the counter core and its helpers.
interface sbcu_ctl_if;
    import sbcu_pkg::*;
    logic [2:0]  cs;          // Tick source select.
    logic        tick;        // Timer tick; held high for source one, held low for source zero, else a one cycle pulse.
    logic [3:0]  wgm;         // Waveform mode select.
    logic [15:0] cmp_a;       // Compare value A.
    logic [15:0] cap;         // Capture value.
    logic [15:0] top_val;     // Highest value of the sequence.
    logic        dual_slope;  // Counts up then down.
    logic        wrap_top;    // Clears after reaching top.
    sbcu_ovf_t   ovf_sel;     // Where overflow is flagged.
    modport tick_mp (input cs, output tick);
    modport mode_mp (input wgm, cmp_a, cap, output top_val, dual_slope, wrap_top, ovf_sel);
    modport core_mp (output cs, wgm, cmp_a, cap,
                     input tick, top_val, dual_slope, wrap_top, ovf_sel);
endinterface // sbcu_ctl_if

//--- design/sbcu_tick_gen.sv
// Tick source selection from the prescaler or the external pin.
module sbcu_tick_gen
    import sbcu_pkg::*;
(
    input wire logic    sys_clk,      // System clock.
    input wire logic    rst,          // Synchronous reset, active high.
    input wire logic    ext_tick_pin, // External tick pin.
    sbcu_ctl_if.tick_mp ctl           // Tick source select in, tick out.
);
    logic [9:0] pre_reg;
    logic [2:0] pin_sync_reg;

    // Free running prescaler.
    always_ff @(posedge sys_clk) begin
        if (rst) pre_reg <= 10'h000;
        else pre_reg <= pre_reg + 10'h001;
    end

    // Two stage synchroniser plus one stage for edge detection.
    always_ff @(posedge sys_clk) begin
        if (rst) pin_sync_reg <= 3'h0;
        else pin_sync_reg <= {pin_sync_reg[1:0], ext_tick_pin};
    end

    // Source zero yields no tick at all, which stops the counter.
    always_comb begin
        case (ctl.cs)
            3'h1:    ctl.tick = 1'b1;
            3'h2:    ctl.tick = (pre_reg & PRE_D8) == PRE_D8;
            3'h3:    ctl.tick = (pre_reg & PRE_D64) == PRE_D64;
            3'h4:    ctl.tick = (pre_reg & PRE_D256) == PRE_D256;
            3'h5:    ctl.tick = pre_reg == PRE_D1024;
            3'h6:    ctl.tick = pin_sync_reg[2] && !pin_sync_reg[1];
            3'h7:    ctl.tick = !pin_sync_reg[2] && pin_sync_reg[1];
            default: ctl.tick = 1'b0;
        endcase
    end
endmodule // sbcu_tick_gen

//--- design/sbcu_mode_dec.sv
// Decode of the waveform mode into top value and count sequence.
module sbcu_mode_dec
    import sbcu_pkg::*;
(
    sbcu_ctl_if.mode_mp ctl // Mode and limit values in, sequence out.
);
    // Each mode selects a top, a slope and the overflow point.
    always_comb begin
        ctl.top_val    = CNT_MAX;
        ctl.dual_slope = 1'b0;
        ctl.wrap_top   = 1'b0;
        ctl.ovf_sel    = OVF_AT_MAX;
        case (ctl.wgm)
            4'h1, 4'h2, 4'h3: begin
                ctl.dual_slope = 1'b1;
                ctl.ovf_sel    = OVF_AT_BOTTOM;
            end
            4'h4, 4'hC: ctl.wrap_top = 1'b1;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
                ctl.wrap_top = 1'b1;
                ctl.ovf_sel  = OVF_AT_TOP;
            end
            4'h8, 4'h9, 4'hA, 4'hB: begin
                ctl.dual_slope = 1'b1;
                ctl.ovf_sel    = OVF_AT_BOTTOM;
            end
            default: ctl.ovf_sel = OVF_AT_MAX;
        endcase
        case (ctl.wgm)
            4'h1, 4'h5:                ctl.top_val = TOP_8B;
            4'h2, 4'h6:                ctl.top_val = TOP_9B;
            4'h3, 4'h7:                ctl.top_val = TOP_10B;
            4'h4, 4'h9, 4'hB, 4'hF:    ctl.top_val = ctl.cmp_a;
            4'h8, 4'hA, 4'hC, 4'hE:    ctl.top_val = ctl.cap;
            default:                   ctl.top_val = CNT_MAX;
        endcase
    end
endmodule // sbcu_mode_dec

//--- tb/sbcu_cpu_model.sv
// Byte wide CPU bus model that drives the counter unit register port.
module sbcu_cpu_model
    import sbcu_pkg::*;
(
    input  wire logic              sys_clk,   // System clock.
    output logic      [ADDR_W-1:0] cpu_addr,  // Byte address.
    output logic                   cpu_wr,    // Write strobe.
    output logic                   cpu_rd,    // Read strobe.
    output logic      [7:0]        cpu_wdata, // Write data.
    input  wire logic [7:0]        cpu_rdata  // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;
    // The bus starts idle with no strobe raised.
    initial begin
        cpu_addr  = 4'hF;
        cpu_wr    = 1'b0;
        cpu_rd    = 1'b0;
        cpu_wdata = 8'h00;
    end
    // One byte access; an idle bus shows inverted values so stale data is never trusted.
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge sys_clk);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = w;
        cpu_rd    = !w;
        @(posedge sys_clk);
        @(negedge sys_clk);
        cpu_wr    = 1'b0;
        cpu_rd    = 1'b0;
        cpu_addr  = ~a;
        cpu_wdata = ~d;
        q         = cpu_rdata;
    endtask
    // Whole word write, high location first, nothing in between.
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, lo + 4'h1, v[15:8], q);
        acc(1'b1, lo, v[7:0], q);
    endtask
    // Whole word read, low location first, nothing in between.
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        acc(1'b0, lo, 8'h00, v[7:0]);
        acc(1'b0, lo + 4'h1, 8'h00, v[15:8]);
    endtask
endmodule // sbcu_cpu_model

//--- tb/tb_top.sv
// Self-checking bench of the sixteen bit counter unit.
module tb_top;
    import sbcu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] val; logic top; logic bot;} sbcu_row_t;
    logic              sys_clk, rst, ext_tick_pin, cnt_at_top, cnt_at_bottom;
    logic              cpu_wr, cpu_rd, count_overflow_flag;
    logic [ADDR_W-1:0] cpu_addr;
    logic [7:0]        cpu_wdata, cpu_rdata, b;
    logic [15:0]       v, w;
    int                n_fail, comparisons, cyc, tops;
    sbcu_row_t         rows [5] = '{'{16'h01FF, 1'b0, 1'b0}, '{16'hFFFF, 1'b1, 1'b0},
        '{16'h0000, 1'b0, 1'b1}, '{16'hA55A, 1'b0, 1'b0}, '{16'h00FF, 1'b0, 1'b0}};
    sbcu_top i_dut (.sys_clk(sys_clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .ext_tick_pin(ext_tick_pin), .count_overflow_flag(count_overflow_flag),
        .cnt_at_top(cnt_at_top), .cnt_at_bottom(cnt_at_bottom));
    sbcu_cpu_model i_cpu (.sys_clk(sys_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
    // Clock of 10 ns period.
    always #5 sys_clk = ~sys_clk;
    // Top hits are counted and a hang is cut short.
    always @(negedge sys_clk) begin
        cyc++;
        if (cnt_at_top === 1'b1) tops++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    // Word comparison.
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Flag comparison.
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask
    // Verdict and end of run.
    task automatic end_sim();
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Clock ticks idle for a number of cycles at falling edges.
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Main sequence.
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        ext_tick_pin = 1'b0;
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        idle(4);
        rst = 1'b0;
        i_cpu.rd16(CNT_LO_OFS, v);
        chk_val(v, CNT_RST);
        i_cpu.acc(1'b0, CTRL_B_OFS, 8'h00, b);
        chk_val({8'h00, b}, 16'h0000);
        i_cpu.acc(1'b0, CTRL_A_OFS, 8'h00, b);
        chk_val({8'h00, b}, 16'h0000);
        chk_bit(cnt_at_bottom, 1'b1);
        chk_bit(count_overflow_flag, 1'b0);
        // Stopped counter: word write, word read, top and bottom marks.
        foreach (rows[i]) begin
            i_cpu.wr16(CNT_LO_OFS, rows[i].val);
            idle(3);
            i_cpu.rd16(CNT_LO_OFS, v);
            chk_val(v, rows[i].val);
            chk_bit(cnt_at_top, rows[i].top);
            chk_bit(cnt_at_bottom, rows[i].bot);
        end
        // One latch write serves two registers; compare high reads bypass it.
        i_cpu.wr16(CNT_LO_OFS, 16'h1234);
        i_cpu.acc(1'b1, CMPA_LO_OFS, 8'h56, b);
        i_cpu.rd16(CMPA_LO_OFS, v);
        chk_val(v, 16'h1256);
        i_cpu.acc(1'b1, CNT_HI_OFS, 8'h77, b);
        i_cpu.acc(1'b0, CMPA_HI_OFS, 8'h00, b);
        chk_val({8'h00, b}, 16'h0012);
        i_cpu.acc(1'b1, CMPB_LO_OFS, 8'h9A, b);
        i_cpu.acc(1'b1, CNT_HI_OFS, 8'h00, b);
        i_cpu.acc(1'b0, CMPB_HI_OFS, 8'h00, b);
        chk_val({8'h00, b}, 16'h0077);
        i_cpu.acc(1'b0, CNT_LO_OFS, 8'h00, b);
        i_cpu.acc(1'b0, CNT_HI_OFS, 8'h00, b);
        chk_val({8'h00, b}, 16'h0012);
        // Unmapped location reads zero and ignores writes.
        i_cpu.acc(1'b1, 4'hF, 8'hAA, b);
        i_cpu.acc(1'b0, 4'hF, 8'h00, b);
        chk_val({8'h00, b}, 16'h0000);
        // Normal mode wraps through the maximum once, one step per tick.
        i_cpu.wr16(CNT_LO_OFS, 16'hFFF0);
        tops = 0;
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h01, b);
        idle(30);
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h00, b);
        chk_val(16'(tops), 16'h0001);
        chk_bit(count_overflow_flag, 1'b1);
        i_cpu.rd16(CNT_LO_OFS, v);
        idle(20);
        i_cpu.rd16(CNT_LO_OFS, w);
        chk_val(w, v);
        chk_val(v, 16'h0010);
        i_cpu.acc(1'b1, FLAG_OFS, 8'h01, b);
        chk_bit(count_overflow_flag, 1'b0);
        // A word write while counting takes the written value.
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h01, b);
        i_cpu.wr16(CNT_LO_OFS, 16'h8000);
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h00, b);
        i_cpu.rd16(CNT_LO_OFS, v);
        chk_val(v, 16'h8002);
        // Pin falling and rising edge sources each count five edges.
        for (int cs = 6; cs < 8; cs++) begin
            i_cpu.wr16(CNT_LO_OFS, 16'h0100);
            i_cpu.acc(1'b1, CTRL_B_OFS, 8'(cs), b);
            repeat (5) begin
                idle(4);
                ext_tick_pin = 1'b1;
                idle(4);
                ext_tick_pin = 1'b0;
            end
            idle(8);
            i_cpu.acc(1'b1, CTRL_B_OFS, 8'h00, b);
            i_cpu.rd16(CNT_LO_OFS, v);
            chk_val(v, 16'h0105);
        end
        // Dual slope with fixed top 0x00FF turns at top and flags at bottom.
        i_cpu.wr16(CNT_LO_OFS, 16'h00F8);
        i_cpu.acc(1'b1, CTRL_A_OFS, 8'h01, b);
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h01, b);
        idle(300);
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h00, b);
        i_cpu.rd16(CNT_LO_OFS, v);
        chk_bit(v <= TOP_8B, 1'b1);
        chk_bit(count_overflow_flag, 1'b1);
        // Clear at top with compare A as top, then ticks at an eighth of the clock.
        i_cpu.wr16(CMPA_LO_OFS, 16'h0009);
        i_cpu.wr16(CNT_LO_OFS, 16'h0000);
        i_cpu.acc(1'b1, CTRL_A_OFS, 8'h00, b);
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h09, b);
        idle(12);
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h0A, b);
        idle(14);
        i_cpu.acc(1'b1, CTRL_B_OFS, 8'h08, b);
        i_cpu.rd16(CNT_LO_OFS, v);
        chk_val(v, 16'h0006);
        // Reset in mid-run clears count, latch, controls and flag.
        i_cpu.acc(1'b1, CNT_HI_OFS, 8'h5A, b);
        rst = 1'b1;
        idle(4);
        rst = 1'b0;
        chk_bit(count_overflow_flag, 1'b0);
        chk_bit(cnt_at_bottom, 1'b1);
        i_cpu.acc(1'b0, CNT_HI_OFS, 8'h00, b);
        chk_val({8'h00, b}, 16'h0000);
        i_cpu.acc(1'b0, CTRL_B_OFS, 8'h00, b);
        chk_val({8'h00, b}, 16'h0000);
        i_cpu.rd16(CNT_LO_OFS, v);
        chk_val(v, CNT_RST);
        end_sim();
    end
endmodule // tb_top
